// ===== verilog/i2cms_top.sv
// two-wire bus master sequencer with command, address and data registers
module i2cms_top
  import i2cms_pkg::*;
(
  input wire logic clk_i, // system clock, 100 MHz
  input wire logic rstn_i, // async reset, active low
  input wire logic cmd_we_i, // write strobe of command_control_reg
  input wire logic [7:0] cmd_i, // command_control_reg write value
  input wire logic sad_we_i, // write strobe of slave_address_reg
  input wire logic [7:0] sad_i, // slave_address_reg write value
  input wire logic data_we_i, // write strobe of transfer_data_reg
  input wire logic [7:0] data_i, // transfer_data_reg write value
  input wire logic [6:0] div_i, // bit_rate_divider value
  input wire logic mask_we_i, // write strobe of irq_mask_bit
  input wire logic mask_i, // irq_mask_bit write value
  input wire logic flag_clr_i, // clears done and nack flags
  input wire logic scl_i, // serial clock line level
  output logic scl_o, // serial clock drive value
  output logic scl_oe_o, // high while pulling scl low
  input wire logic sda_i, // serial data line level
  output logic sda_o, // serial data drive value
  output logic sda_oe_o, // high while pulling sda low
  output logic [7:0] sad_o, // slave_address_reg read value
  output logic [7:0] data_o, // transfer_data_reg read value
  output logic byte_done_o, // byte_done_flag
  output logic addr_nack_o, // addr_nack_flag
  output logic data_nack_o, // data_nack_flag
  output logic mask_o, // irq_mask_bit read value
  output logic irq_o, // completion request, gated by mask
  output logic busy_o, // sequence running on the bus
  output logic bus_held_o // bus kept between commands
);
  i2cms_tick_if tk (); // tick link to the divider

  // sequencer state
  i2cms_state_t state_q, state_d;
  logic [2:0] ph_q, ph_d; // phase within a bit
  logic [2:0] bit_q, bit_d; // bit index within a byte
  logic [7:0] sh_q, sh_d; // shift register
  logic hold_q, hold_d; // latched hold_bus_bit
  logic sbyte_q, sbyte_d; // start byte sequence
  logic rx_q, rx_d; // latched direction, 1 = receive
  logic an_q, an_d; // pending address nack
  logic dn_q, dn_d; // pending data nack
  // software visible registers
  logic [7:0] sad_q, sad_d; // slave_address_reg
  logic [7:0] dat_q, dat_d; // transfer_data_reg
  logic done_q, done_d; // byte_done_flag
  logic af_q, af_d; // addr_nack_flag
  logic df_q, df_d; // data_nack_flag
  logic mask_q, mask_d; // irq_mask_bit
  // pin drive
  logic scl_low_q, scl_low_d; // pull scl low
  logic sda_low_q, sda_low_d; // pull sda low
  // line synchronisers, three stages each
  logic [1:0] s1_q, s2_q, s3_q; // {scl, sda} stages
  logic [1:0] ln_q, ln_d; // filtered {scl, sda}
  // helpers
  logic idle_or_hold; // ready for a command
  logic go; // accepted command
  logic last; // last tick of a bit
  logic sample; // sda sample tick
  logic stall; // slave stretches the clock
  logic finish; // sequence ends this cycle
  logic stopped; // stop sequence ends this cycle

  assign tk.div = div_i;

  i2cms_tick u_tick (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tk(tk)
  );

  // line synchroniser stages
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
    end else begin
      s1_q <= {scl_i, sda_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a line level once stages two and three agree
  always_comb begin
    ln_d = ln_q;
    for (int i = 0; i < 2; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        ln_d[i] = s3_q[i];
      end
    end
  end

  // control decodes
  always_comb begin
    idle_or_hold = (state_q == I2CMS_IDLE) || (state_q == I2CMS_HOLD);
    go = cmd_we_i && cmd_i[CMD_BEGIN_BIT] && idle_or_hold;
    stall = (ph_q == PH_STRETCH) && !scl_low_q && !ln_q[1];
    last = tk.tick && (ph_q == PH_LAST);
    sample = tk.tick && (ph_q == PH_SAMPLE);
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    ph_d = ph_q;
    bit_d = bit_q;
    sh_d = sh_q;
    hold_d = hold_q;
    sbyte_d = sbyte_q;
    rx_d = rx_q;
    an_d = an_q;
    dn_d = dn_q;
    finish = 1'b0;
    stopped = 1'b0;
    if (tk.tick && !stall && (state_q != I2CMS_IDLE) && (state_q != I2CMS_HOLD)) begin
      ph_d = ph_q + 3'h1;
    end
    case (state_q)
      I2CMS_IDLE, I2CMS_HOLD: begin
        if (go) begin
          hold_d = cmd_i[CMD_HOLD_BIT];
          sbyte_d = cmd_i[CMD_SBYTE_BIT];
          rx_d = sad_q[SAD_DIR_BIT];
          an_d = 1'b0;
          dn_d = 1'b0;
          ph_d = 3'h0;
          bit_d = BIT_MSB;
          if (state_q == I2CMS_IDLE || cmd_i[CMD_RESTART_BIT] || cmd_i[CMD_SBYTE_BIT]) begin
            state_d = I2CMS_START;
          end else begin
            state_d = I2CMS_DATA; // next byte of a held session
            sh_d = dat_q;
          end
        end
      end
      I2CMS_START: begin
        if (last) begin
          state_d = I2CMS_ADDR;
          sh_d = sad_q;
          bit_d = BIT_MSB;
        end
      end
      I2CMS_ADDR: begin
        if (last) begin
          sh_d = {sh_q[6:0], 1'b0};
          bit_d = bit_q - 3'h1;
          if (bit_q == 3'h0) begin
            state_d = I2CMS_AACK;
          end
        end
      end
      I2CMS_AACK: begin
        if (sample && !sbyte_q) begin
          an_d = ln_q[0];
        end
        if (last) begin
          if (sbyte_q) begin
            finish = 1'b1; // start byte carries no data
          end else begin
            state_d = I2CMS_DATA;
            sh_d = dat_q;
            bit_d = BIT_MSB;
          end
        end
      end
      I2CMS_DATA: begin
        if (sample && rx_q) begin
          sh_d = {sh_q[6:0], ln_q[0]};
        end
        if (last) begin
          if (!rx_q) begin
            sh_d = {sh_q[6:0], 1'b0};
          end
          bit_d = bit_q - 3'h1;
          if (bit_q == 3'h0) begin
            state_d = I2CMS_DACK;
          end
        end
      end
      I2CMS_DACK: begin
        if (sample && !rx_q) begin
          dn_d = ln_q[0];
        end
        if (last) begin
          finish = 1'b1;
        end
      end
      I2CMS_STOP: begin
        if (last) begin
          state_d = I2CMS_IDLE;
          stopped = 1'b1;
        end
      end
      default: begin
        state_d = I2CMS_IDLE;
      end
    endcase
    if (finish) begin
      ph_d = 3'h0;
      state_d = hold_q ? I2CMS_HOLD : I2CMS_STOP;
    end
  end

  // pin drive for the coming cycle
  always_comb begin
    scl_low_d = 1'b0;
    sda_low_d = 1'b0;
    case (state_q)
      I2CMS_IDLE: begin
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
      end
      I2CMS_HOLD: begin
        scl_low_d = 1'b1; // bus kept occupied
        sda_low_d = scl_low_q ? 1'b0 : sda_low_q; // keep ack until scl is low, no false stop
      end
      I2CMS_START: begin
        scl_low_d = ph_q < PH_START_SCL;
        sda_low_d = ph_q >= PH_SCL_HIGH;
      end
      I2CMS_ADDR: begin
        scl_low_d = ph_q < PH_SCL_HIGH;
        sda_low_d = (ph_q == 3'h0) ? sda_low_q : !sh_q[7];
      end
      I2CMS_DATA: begin
        scl_low_d = ph_q < PH_SCL_HIGH;
        sda_low_d = (ph_q == 3'h0) ? sda_low_q : (!rx_q && !sh_q[7]);
      end
      I2CMS_AACK: begin
        scl_low_d = ph_q < PH_SCL_HIGH;
        sda_low_d = (ph_q == 3'h0) ? sda_low_q : 1'b0;
      end
      I2CMS_DACK: begin
        scl_low_d = ph_q < PH_SCL_HIGH;
        sda_low_d = (ph_q == 3'h0) ? sda_low_q : (rx_q && hold_q);
      end
      I2CMS_STOP: begin
        scl_low_d = ph_q < PH_SCL_HIGH;
        sda_low_d = (ph_q == 3'h0) ? sda_low_q : (ph_q < PH_STOP_SDA);
      end
      default: begin
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
      end
    endcase
  end

  // software registers and flags; hardware set wins over clear
  always_comb begin
    sad_d = sad_q;
    dat_d = dat_q;
    mask_d = mask_q;
    done_d = flag_clr_i ? 1'b0 : done_q;
    af_d = flag_clr_i ? 1'b0 : af_q;
    df_d = flag_clr_i ? 1'b0 : df_q;
    if (sad_we_i && idle_or_hold) begin
      sad_d = sad_i;
    end
    if (data_we_i && idle_or_hold) begin
      dat_d = data_i;
    end
    if (mask_we_i) begin
      mask_d = mask_i;
    end
    if (finish && rx_q && !sbyte_q) begin
      dat_d = sh_q;
    end
    if ((finish && hold_q) || stopped) begin
      done_d = 1'b1;
      af_d = af_d | an_q;
      df_d = df_d | dn_q;
    end
  end

  // register all state except the synchroniser stages
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= I2CMS_IDLE;
      ph_q <= 3'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      hold_q <= 1'b0;
      sbyte_q <= 1'b0;
      rx_q <= 1'b0;
      an_q <= 1'b0;
      dn_q <= 1'b0;
      sad_q <= SAD_RESET;
      dat_q <= DATA_RESET;
      done_q <= 1'b0;
      af_q <= 1'b0;
      df_q <= 1'b0;
      mask_q <= MASK_RESET;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      ln_q <= 2'h3;
    end else begin
      state_q <= state_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      hold_q <= hold_d;
      sbyte_q <= sbyte_d;
      rx_q <= rx_d;
      an_q <= an_d;
      dn_q <= dn_d;
      sad_q <= sad_d;
      dat_q <= dat_d;
      done_q <= done_d;
      af_q <= af_d;
      df_q <= df_d;
      mask_q <= mask_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      ln_q <= ln_d;
    end
  end

  // outputs; open-drain lines only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_low_q;
  assign sda_oe_o = sda_low_q;
  assign sad_o = sad_q;
  assign data_o = dat_q;
  assign byte_done_o = done_q;
  assign addr_nack_o = af_q;
  assign data_nack_o = df_q;
  assign mask_o = mask_q;
  assign irq_o = done_q && !mask_q;
  assign busy_o = !idle_or_hold;
  assign bus_held_o = state_q == I2CMS_HOLD;
endmodule : i2cms_top

// ===== verilog/i2cms_pkg.sv
// package of constants for the two-wire bus master sequencer
package i2cms_pkg;
  // command word bit positions
  localparam int unsigned CMD_RESTART_BIT = 0; // repeated_start_bit
  localparam int unsigned CMD_HOLD_BIT = 1; // hold_bus_bit
  localparam int unsigned CMD_BEGIN_BIT = 2; // begin_sequence_bit
  localparam int unsigned CMD_SBYTE_BIT = 4; // start byte request
  // address register layout
  localparam int unsigned SAD_DIR_BIT = 0; // direction_bit, 1 = master receives
  // widths
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned DIV_W = 7; // bit_rate_divider width
  // reset values
  localparam logic [7:0] SAD_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [6:0] DIV_RESET = 7'h00;
  localparam logic MASK_RESET = 1'b1; // irq_mask_bit set after reset
  // bit timing: eight divider ticks per bit
  localparam logic [2:0] PH_LAST = 3'h7; // last phase of a bit
  localparam logic [2:0] PH_SCL_HIGH = 3'h4; // scl released from here
  localparam logic [2:0] PH_STRETCH = 3'h5; // wait here while slave holds scl
  localparam logic [2:0] PH_SAMPLE = 3'h6; // sda sampled here
  localparam logic [2:0] PH_START_SCL = 3'h2; // start: scl released
  localparam logic [2:0] PH_STOP_SDA = 3'h6; // stop: sda released
  localparam logic [2:0] BIT_MSB = 3'h7; // first bit of a byte
  // sequencer states
  typedef enum logic [2:0] {
    I2CMS_IDLE,
    I2CMS_START,
    I2CMS_ADDR,
    I2CMS_AACK,
    I2CMS_DATA,
    I2CMS_DACK,
    I2CMS_STOP,
    I2CMS_HOLD
  } i2cms_state_t;
endpackage : i2cms_pkg

// ===== verilog/i2cms_tick_if.sv
// interface between the sequencer and its bit rate tick generator
interface i2cms_tick_if;
  import i2cms_pkg::*;
  logic [DIV_W-1:0] div; // bit_rate_divider value
  logic tick; // one-cycle pulse, eight per serial bit
  modport gen (input div, output tick);
  modport use_side (output div, input tick);
endinterface : i2cms_tick_if

// ===== verilog/i2cms_tick.sv
// divider that paces the serial bit phases
module i2cms_tick
  import i2cms_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rstn_i, // async reset, active low
  i2cms_tick_if.gen tk // divider in, tick out
);
  logic [DIV_W-1:0] cnt_q; // phase counter
  logic [DIV_W-1:0] cnt_d;
  logic tick_q; // registered tick
  logic tick_d;

  // next count; divider of zero clears the counter and stops the tick
  always_comb begin
    if (tk.div == DIV_RESET) begin
      cnt_d = DIV_RESET;
      tick_d = 1'b0;
    end else if (cnt_q >= tk.div - 7'h01) begin
      cnt_d = DIV_RESET;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 7'h01;
      tick_d = 1'b0;
    end
  end

  // register the counter and tick
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;
endmodule : i2cms_tick

// ===== testbench/i2cms_slave.sv
// behavioural slave on the pulled-up open-drain bus
module i2cms_slave #(
  parameter logic [6:0] ADDR = 7'h2A // own address
) (
  input wire logic scl_i, // clock level
  input wire logic sda_i, // data level
  input wire logic nak_i, // refuse written bytes
  input wire logic [7:0] base_i, // first read byte
  output logic sda_oe_o, // pulls sda low
  output logic mnak_o, // master refused a byte
  output int wr_n_o, // bytes taken
  output logic [7:0] got_o // last byte taken
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 8; // clocks in byte
  int bc = 0; // read byte index
  logic act = 1'h0; // in a transfer
  logic ap, rd, sel; // address phase, read, selected
  logic [7:0] sh, tx; // shift in, byte out
  initial begin
    sda_oe_o = 1'h0;
    wr_n_o = 0;
    mnak_o = 1'h0;
  end
  // start or repeated start
  always @(negedge sda_i) if (scl_i === 1'h1) begin
    act = 1'h1;
    ap = 1'h1;
    n = -1;
    bc = -1;
    mnak_o = 1'h0;
  end
  // stop
  always @(posedge sda_i) if (scl_i === 1'h1) act = 1'h0;
  // sample on rising clock
  always @(posedge scl_i) if (act) begin
    if (n < 8) sh = {sh[6:0], sda_i}; // msb first
    else if (rd && !ap) mnak_o = sda_i;
  end
  // drive on falling clock
  always @(negedge scl_i) if (act) begin
    sda_oe_o = 1'h0;
    if (n == 8) begin
      ap = 1'h0;
      n = 0;
      bc++;
    end else n++;
    tx = base_i + 8'(bc);
    if (n == 8 && ap) begin
      sel = sh[7:1] == ADDR;
      rd = sh[0];
      sda_oe_o = sel;
    end else if (n == 8 && !rd && sel && !nak_i) begin
      got_o = sh;
      wr_n_o++;
      sda_oe_o = 1'h1;
    end else if (n < 8 && rd && sel && !ap && !mnak_o) sda_oe_o = !tx[7-n];
  end
endmodule : i2cms_slave

// ===== testbench/i2cms_top_asserts.sv
// port checker of the sequencer
module i2cms_asserts
  import i2cms_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset, low
  input wire logic cmd_we_i, // command strobe
  input wire logic [7:0] cmd_i, // command
  input wire logic flag_clr_i, // flag clear
  input wire logic [6:0] div_i, // divider
  input wire logic scl_oe_o, // scl pulled
  input wire logic sda_oe_o, // sda pulled
  input wire logic [7:0] sad_o, // address reg
  input wire logic byte_done_o, // done flag
  input wire logic addr_nack_o, // nack flag
  input wire logic mask_o, // mask
  input wire logic irq_o, // request
  input wire logic busy_o, // running
  input wire logic bus_held_o // bus kept
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // idle, mask set after reset
  AST_RST_VAL: assert property ($rose(rstn_i) |-> mask_o && !busy_o && !byte_done_o)
    else $error("reset state");
  AST_IRQ_GATE: assert property (irq_o == (byte_done_o && !mask_o))
    else $error("irq gate");
  AST_BEGIN: assert property (cmd_we_i && cmd_i[CMD_BEGIN_BIT] && !busy_o |=> busy_o)
    else $error("begin not taken");
  AST_NO_BEGIN: assert property (cmd_we_i && !cmd_i[CMD_BEGIN_BIT] && !busy_o |=> !busy_o)
    else $error("started without begin");
  AST_SAD_LOCK: assert property (busy_o ##1 busy_o |-> $stable(sad_o))
    else $error("write taken while busy");
  AST_HOLD_SCL: assert property (bus_held_o ##1 bus_held_o |-> scl_oe_o)
    else $error("bus not kept");
  AST_STOP_FREE: assert property ($fell(busy_o) && !bus_held_o |-> !scl_oe_o && !sda_oe_o)
    else $error("bus not released");
  AST_NACK_STAND: assert property (addr_nack_o && !flag_clr_i |=> addr_nack_o)
    else $error("nack flag lost");
  AST_DIV_STOP: assert property (div_i == 7'h00 [*3] |-> $stable(scl_oe_o) && $stable(sda_oe_o))
    else $error("ran with zero divider");
  CV_HELD: cover property ($rose(bus_held_o));
  CV_NACK: cover property ($rose(addr_nack_o));
  CV_IRQ: cover property ($rose(irq_o));
endmodule : i2cms_asserts
bind i2cms_top i2cms_asserts u_ast (.clk_i, .rstn_i, .cmd_we_i, .cmd_i, .flag_clr_i, .div_i, .scl_oe_o,
  .sda_oe_o, .sad_o, .byte_done_o, .addr_nack_o, .mask_o, .irq_o, .busy_o, .bus_held_o);

// ===== testbench/i2c_master_sequencer_tb.sv
// self-checking bench of the sequencer with a slave model
module i2c_master_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rstn_i = 0, cmd_we_i = 0, sad_we_i = 0, data_we_i = 0, mask_we_i = 0, mask_i = 0;
  logic flag_clr_i = 0, nak = 0, pb = 0, scl_oe, sda_oe, s_oe, mnak, scl_w, sda_w;
  logic [7:0] cmd_i = 8'h00, sad_i = 8'h00, data_i = 8'h00, base = 8'h00, r, got, sad_o, data_o;
  logic [6:0] div_i = 7'h08; // eight cycles a tick
  logic byte_done_o, addr_nack_o, data_nack_o, mask_o, irq_o, busy_o, bus_held_o;
  int num_errors = 0, total_checks = 0, wr_n;
  typedef struct packed {logic [7:0] d; logic [5:0] f;} i2cms_exp_t;
  i2cms_exp_t eq[$], e; // notes per sequence
  logic [7:0] wq[$]; // bytes the slave should take
  assign scl_w = !scl_oe; // pulled-up wires
  assign sda_w = !(sda_oe || s_oe);
  // clock
  always #5 clk_i = !clk_i;
  i2cms_top u_dut (.clk_i, .rstn_i, .cmd_we_i, .cmd_i, .sad_we_i, .sad_i, .data_we_i, .data_i, .div_i,
    .mask_we_i, .mask_i, .flag_clr_i, .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_w),
    .sda_o(), .sda_oe_o(sda_oe), .sad_o, .data_o, .byte_done_o, .addr_nack_o, .data_nack_o,
    .mask_o, .irq_o, .busy_o, .bus_held_o);
  i2cms_slave u_slv (.scl_i(scl_w), .sda_i(sda_w), .nak_i(nak), .base_i(base), .sda_oe_o(s_oe),
    .mnak_o(mnak), .wr_n_o(wr_n), .got_o(got));
  // byte compare
  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    total_checks++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk8
  // flag compare
  task automatic chk1(input logic g, input logic x);
    chk8({7'h00, g}, {7'h00, x});
  endtask : chk1
  // verdict
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // one sequence; f = addr nack, data nack, held, done, slave takes, freeze
  task automatic seq(input logic [7:0] s, input logic [7:0] c, input logic [7:0] x, input logic [5:0] f);
    int k;
    r = 8'($urandom);
    eq.push_back({(!s[0] || c[4]) ? r : x, f});
    if (f[1]) wq.push_back(r);
    @(posedge clk_i);
    {sad_we_i, data_we_i, flag_clr_i} <= 3'h7;
    sad_i <= s;
    data_i <= r;
    @(posedge clk_i);
    {sad_we_i, data_we_i, flag_clr_i, cmd_we_i} <= 4'h1;
    cmd_i <= c;
    @(posedge clk_i);
    {sad_we_i, data_we_i} <= 2'h3; // ignored while busy
    sad_i <= ~s;
    data_i <= ~r;
    @(posedge clk_i);
    {sad_we_i, data_we_i, cmd_we_i} <= 3'h0;
    if (f[0]) begin
      div_i <= 7'h00;
      repeat (200) @(posedge clk_i);
      div_i <= 7'h08;
    end
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (busy_o !== 1'h0 && k < 4000);
    if (k >= 4000) chk1(1'h0, 1'h1);
  endtask : seq
  // end of sequence: oldest note against outputs
  always @(negedge clk_i) begin
    pb <= busy_o;
    if (pb === 1'h1 && busy_o === 1'h0 && eq.size() > 0) begin
      e = eq.pop_front();
      chk8(data_o, e.d);
      chk1(addr_nack_o, e.f[5]);
      chk1(data_nack_o, e.f[4]);
      chk1(bus_held_o, e.f[3]);
      if (e.f[2]) chk1(byte_done_o, 1'h1);
    end
  end
  // bytes the slave took
  always @(wr_n) if (wr_n > 0) chk8(got, wq.pop_front());
  // watchdog
  initial begin
    repeat (40000) @(posedge clk_i);
    chk1(1'h0, 1'h1);
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'h40E6BFE8));
    base = 8'($urandom);
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'h1;
    @(negedge clk_i);
    chk1(mask_o, 1'h1);
    seq(8'h54, 8'h04, 8'h00, 6'h06);
    @(posedge clk_i);
    {mask_we_i, mask_i} <= 2'h2;
    @(posedge clk_i);
    mask_we_i <= 1'h0;
    {flag_clr_i, cmd_we_i} <= 2'h3;
    cmd_i <= 8'h02;
    @(negedge clk_i);
    chk1(irq_o, 1'h1);
    @(posedge clk_i);
    {flag_clr_i, cmd_we_i} <= 2'h0;
    @(negedge clk_i);
    chk1(irq_o, 1'h0);
    chk1(busy_o, 1'h0);
    seq(8'h55, 8'h06, base, 6'h0D);
    seq(8'h55, 8'h06, base + 8'h01, 6'h0C);
    chk1(mnak, 1'h0);
    seq(8'h55, 8'h04, base + 8'h02, 6'h04);
    chk1(mnak, 1'h1);
    seq(8'h54, 8'h06, 8'h00, 6'h0E);
    seq(8'h55, 8'h05, base, 6'h04);
    seq(8'h2A, 8'h04, 8'h00, 6'h34);
    seq(8'h2B, 8'h04, 8'hFF, 6'h24);
    for (int i = 0; i < 2; i++) begin
      seq(8'h01, 8'h16, 8'h00, 6'h08);
      seq(i ? 8'h2A : 8'h54, 8'h05, 8'h00, i ? 6'h34 : 6'h06);
    end
    nak = 1'h1;
    seq(8'h54, 8'h04, 8'h00, 6'h14);
    finish_test();
  end
endmodule : i2c_master_sequencer_tb
